// File: logic/efs_pkg.sv
// Package of register offsets, field positions, reset values and timing counts
package efs_pkg;

  // ------------------------------------------------------------
  // Clock
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 250;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_THERMAL_SHUTDOWN = 8'h4F;
  localparam logic [7:0] OFS_THERMAL_WARNING  = 8'h51;
  localparam logic [7:0] OFS_INPUT_OV         = 8'h55;
  localparam logic [7:0] OFS_PEAK_CURRENT     = 8'hC4;
  localparam logic [7:0] OFS_PROTECTION_CFG   = 8'hC9;
  localparam logic [7:0] OFS_STATUS           = 8'hE0;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_THERMAL_SHUTDOWN = 16'h0096;
  localparam logic [15:0] RST_THERMAL_WARNING  = 16'h0082;
  localparam logic [15:0] RST_INPUT_OV         = 16'h0000;
  localparam logic [15:0] RST_PROTECTION_CFG   = 16'h0001;

  // ------------------------------------------------------------
  // Protection configuration fields
  // ------------------------------------------------------------
  localparam int CFG_RETRY_BIT  = 0;
  localparam int CFG_OC1_LVL_LO = 2;
  localparam int CFG_OC2_LVL_LO = 4;
  localparam int CFG_OC3_EN_BIT = 6;
  localparam int CFG_OC1_DLY_LO = 8;
  localparam int CFG_OC2_DLY_LO = 11;
  localparam int CFG_OC3_DLY_LO = 14;
  localparam logic [1:0] OC_LEVEL_NONE = 2'h0;

  // ------------------------------------------------------------
  // Status register fields
  // ------------------------------------------------------------
  localparam int ST_PG_BIT      = 0;
  localparam int ST_TEMP_BIT    = 1;
  localparam int ST_GOK_BIT     = 2;
  localparam int ST_INVALID_BIT = 3;
  localparam int ST_OC_BIT      = 4;
  localparam int ST_OFF_BIT     = 5;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int HYST_US    = 100;
  localparam int HYST_CYC   = HYST_US * CLK_MHZ;
  localparam int FC_DLY_NS  = 500;
  localparam int FC_DLY_CYC = (FC_DLY_NS * CLK_MHZ + 999) / 1000;
  localparam int DEB_MIN_US = 250;
  localparam int DEB_MAX_US = 50000;

  // Startup current limit codes, in units of 0.5 A
  localparam logic [7:0] LIM_LO_0 = 8'h0F;
  localparam logic [7:0] LIM_LO_1 = 8'h1E;
  localparam logic [7:0] LIM_LO_2 = 8'h3C;
  localparam logic [7:0] LIM_HI_0 = 8'h0A;
  localparam logic [7:0] LIM_HI_1 = 8'h14;
  localparam logic [7:0] LIM_HI_2 = 8'h28;

  typedef enum logic [1:0] {ROLE_SOLO, ROLE_MASTER, ROLE_SLAVE} efs_role_type;

endpackage

// File: logic/efs_oc_timer.sv
// One overcurrent level: debounce timer with hysteresis reset timer
module efs_oc_timer #(
  parameter int DEB_W  = 24,
  parameter int HYST_C = efs_pkg::HYST_CYC
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Control
  input  wire logic             enable,
  input  wire logic [DEB_W-1:0] debounce_cyc,
  input  wire logic             over,
  input  wire logic             below_hyst,
  // Result
  output logic                  expired
);

  initial begin
    if (HYST_C < 1 || DEB_W < $clog2(HYST_C + 1)) $error("efs_oc_timer: bad parameters");
  end

  logic [DEB_W-1:0] deb_r;
  logic [DEB_W-1:0] hyst_r;
  logic             run_r;
  logic             exp_r;
  wire              hyst_done = (hyst_r >= DEB_W'(HYST_C - 1));
  wire              deb_done  = run_r && (deb_r >= debounce_cyc);

  always_ff @(posedge clk) begin
    if (rst || !enable || !run_r || !below_hyst) begin
      hyst_r <= '0;
    end else begin
      hyst_r <= hyst_r + DEB_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !enable || (run_r && below_hyst && hyst_done)) begin
      run_r <= 1'b0;
      deb_r <= '0;
      exp_r <= 1'b0;
    end else if (run_r) begin
      deb_r <= deb_r + DEB_W'(1);
      exp_r <= exp_r | deb_done;
    end else if (over) begin
      run_r <= 1'b1;
      deb_r <= '0;
    end
  end

  assign expired = exp_r;

  a_hyst_resets_timer: assert property (@(posedge clk) disable iff (rst)
    (run_r && below_hyst && hyst_done && enable) |=> !run_r) else $error("debounce not reset");

endmodule

// File: logic/efs_supervisor.sv
// Fault supervisor of a hot-swap electronic fuse
//
// Overview of operation
// - Hold power-good low in soft-start until output near input and gate high.
// - Any fault or host disable drives power-good low and sets its flag.
// - After thermal retry, wait for cool below warning plus retry delay.
// - Peak current captured on overcurrent, only higher replaces, cleared on read.
// - Low input: start limit 7.5, 15, 30 A by output-to-input ratio.
// - High input: start limit 5, 10, 20 A by output-to-input ratio.
// - Once power good, arm overcurrent protection; start limit output stays active in every state.
// - Current limiting beyond timeout latches off or retries after delay.
// - At soft-start timer end, fault unless output and gate both good.
// - Severe short pulls gate low at once, then latch or retry.
// - First and second levels run together; level zero disables.
// - Each level has its own debounce time from 0.25 to 50 ms.
// - Current below hysteresis for 100 us resets the debounce timer.
// - Overcurrent expiry: solo turns off, slave reports, master commands shutdown.
// - Above warning sets temperature bit; above shutdown turns device off.
// - Thermal recovery waits for cool; latch mode also needs re-enable.
// - Shutdown threshold at or below warning threshold flags invalid data.
// - Master alone alerts on input-output short while disabled, without latching.
// - Gate-input short alerts while disabled; gate leakage asserts alert and latches or retries.
// - Slave health fault reports; master commands all devices off.
// - Gate-ok flag reports shorts when off and failed soft-start check.
// - Restart policy bit one selects retry, zero selects latch-off.
// - Latched device stays off until enable is toggled.
// - Slave ignores its restart policy bit.
module efs_supervisor #(
  parameter int RETRY_CYC = 25000000,
  parameter int CLREG_CYC = 1250000,
  parameter int SSFLT_CYC = 50000000,
  parameter int DEB_W     = 24,
  parameter int CUR_W     = 10
) (
  // Clock and reset
  input  wire logic             REF_CLK,
  input  wire logic             RST,
  // Enable and role
  input  wire logic             ON,
  input  wire logic             HOST_ENABLE,
  input  wire logic [1:0]       ROLE,
  // Analog comparators
  input  wire logic             VOUT_NEAR_VIN,
  input  wire logic             VGS_ABOVE_6V3,
  input  wire logic             VIN_ABOVE_13V2,
  input  wire logic             VOUT_ABOVE_0P4,
  input  wire logic             VOUT_ABOVE_0P8,
  input  wire logic             VOUT_ABOVE_LOW_TH,
  input  wire logic             VGS_ABOVE_GATE_TH,
  input  wire logic             IN_CURRENT_LIMIT,
  input  wire logic             SHORT_DETECT,
  input  wire logic             VOUT_ABOVE_DS_TH,
  input  wire logic             VOUT_BELOW_DS_OK,
  input  wire logic             GATE_ABOVE_DG_TH,
  input  wire logic             VIN_FAULT,
  input  wire logic [3:1]       OC_OVER,
  input  wire logic [3:1]       OC_BELOW_HYST,
  input  wire logic [CUR_W-1:0] CURRENT_MONITOR,
  input  wire logic [15:0]      DIE_TEMP,
  // Register port
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  input  wire logic [15:0]      REG_WDATA,
  output logic [15:0]           REG_RDATA,
  // Power path
  output logic                  GATE_ON,
  output logic                  GATE_PULL_FAST,
  output logic [7:0]            START_LIMIT,
  output logic                  OCP_ACTIVE,
  output logic [1:0]            OC_LEVEL1,
  output logic [1:0]            OC_LEVEL2,
  // Open-drain pins, enable low while driving low
  output logic                  POWER_GOOD_OUTPUT_O,
  output logic                  POWER_GOOD_OUTPUT_OE_N,
  output logic                  ALERT_N_O,
  output logic                  ALERT_N_OE_N,
  input  wire logic             FAULT_CMD_N_I,
  output logic                  FAULT_CMD_N_O,
  output logic                  FAULT_CMD_N_OE_N,
  input  wire logic             FAULT_RPT_N_I,
  output logic                  FAULT_RPT_N_O,
  output logic                  FAULT_RPT_N_OE_N
);

  initial begin
    if (RETRY_CYC < 1 || CLREG_CYC < 1 || SSFLT_CYC < 2 || CUR_W > 16 || DEB_W < 24 ||
        RETRY_CYC > 2**26 || SSFLT_CYC > 2**26 || CLREG_CYC >= 2**22)
      $error("efs_supervisor: bad parameters");
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [15:0]      tsd_r, twarn_r, inov_r, cfg_r;
  logic [CUR_W-1:0] peak_r;
  logic [15:0]      rdata_r;

  wire  is_slave  = (ROLE == 2'(efs_pkg::ROLE_SLAVE));
  wire  is_master = (ROLE == 2'(efs_pkg::ROLE_MASTER));
  // restart policy, slave defers to master
  wire  retry_mode = cfg_r[efs_pkg::CFG_RETRY_BIT] && !is_slave;
  wire  invalid_thr = (tsd_r <= twarn_r);
  wire  temp_warn   = (DIE_TEMP > twarn_r);
  wire  temp_sd     = (DIE_TEMP > tsd_r) && !invalid_thr;

  function automatic logic [DEB_W-1:0] deb_cycles(input logic [1:0] code);
    case (code)
      2'h0:    deb_cycles = DEB_W'(efs_pkg::DEB_MIN_US * efs_pkg::CLK_MHZ);
      2'h1:    deb_cycles = DEB_W'(1000 * efs_pkg::CLK_MHZ);
      2'h2:    deb_cycles = DEB_W'(10000 * efs_pkg::CLK_MHZ);
      default: deb_cycles = DEB_W'(efs_pkg::DEB_MAX_US * efs_pkg::CLK_MHZ);
    endcase
  endfunction

  // ------------------------------------------------------------
  // State machine
  // ------------------------------------------------------------
  typedef enum logic [2:0] {S_OFF, S_SOFT, S_ON, S_WAIT, S_LATCH} efs_state_type;
  efs_state_type state_r, state_nxt;

  logic [25:0] cnt_r;
  logic [21:0] cl_r;
  logic        on_d_r, pg_flag_r, gok_r, temp_bit_r, oc_flag_r, thermal_r;
  logic [7:0]  fc_dly_r;
  logic        fc_drive_r, fr_drive_r, alert_r;

  wire enabled    = ON && HOST_ENABLE;
  wire on_rise    = ON && !on_d_r;
  wire ds_short   = is_master && !enabled && VOUT_ABOVE_DS_TH;
  wire ds_blocked = ds_short || (is_master && alert_r && !VOUT_BELOW_DS_OK && !enabled);
  // gate to input short while disabled
  wire dg_short   = !enabled && GATE_ABOVE_DG_TH;
  wire pg_ok      = VOUT_NEAR_VIN && VGS_ABOVE_6V3;
  wire ss_end     = (state_r == S_SOFT) && (cnt_r >= 26'(SSFLT_CYC - 1));
  wire ss_bad     = ss_end && !(VOUT_ABOVE_LOW_TH && VGS_ABOVE_GATE_TH);
  wire gate_leak  = (state_r == S_ON) && !VGS_ABOVE_GATE_TH;
  wire cl_fault   = (cl_r >= 22'(CLREG_CYC));
  logic [3:1] oc_exp;
  wire oc_fault   = |oc_exp;
  wire health     = ss_bad || gate_leak || dg_short;
  wire own_fault  = SHORT_DETECT || cl_fault || oc_fault || temp_sd || VIN_FAULT || health;
  // master and slaves all stop on the shared command line, master reads back its own
  wire ext_fault  = (is_master || is_slave) && !FAULT_CMD_N_I;
  wire running    = (state_r == S_SOFT) || (state_r == S_ON);
  wire fault      = running && (own_fault || ext_fault);
  wire cool       = !temp_warn;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_OFF:   if (enabled && !ds_blocked && !dg_short && cool) state_nxt = S_SOFT;
      S_SOFT:  if (!enabled) state_nxt = S_OFF;
               else if (fault) state_nxt = retry_mode ? S_WAIT : S_LATCH;
               else if (pg_ok) state_nxt = S_ON;
      // fault or disable leaves the on state
      S_ON:    if (!enabled) state_nxt = S_OFF;
               else if (fault) state_nxt = retry_mode ? S_WAIT : S_LATCH;
      // retry waits for cool die and delay
      S_WAIT:  if (!enabled) state_nxt = S_OFF;
               else if (cnt_r >= 26'(RETRY_CYC - 1) && cool) state_nxt = S_SOFT;
      // latch released only by enable toggle
      S_LATCH: if (on_rise && cool) state_nxt = S_SOFT;
      default: state_nxt = S_OFF;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_r <= S_OFF;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt != state_r) ? '0 : (cnt_r == '1 ? cnt_r : cnt_r + 26'(1));
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST || !IN_CURRENT_LIMIT || !running) cl_r <= '0;
    else if (!cl_fault) cl_r <= cl_r + 22'(1);
  end

  // ------------------------------------------------------------
  // Overcurrent levels
  // ------------------------------------------------------------
  wire [1:0] lvl1 = cfg_r[efs_pkg::CFG_OC1_LVL_LO +: 2];
  wire [1:0] lvl2 = cfg_r[efs_pkg::CFG_OC2_LVL_LO +: 2];
  wire       ocp_arm = (state_r == S_ON);
  wire [3:1] oc_en;
  assign oc_en[1] = ocp_arm && (lvl1 != efs_pkg::OC_LEVEL_NONE);
  assign oc_en[2] = ocp_arm && (lvl2 != efs_pkg::OC_LEVEL_NONE);
  // third level used only with both lower levels off
  assign oc_en[3] = ocp_arm && cfg_r[efs_pkg::CFG_OC3_EN_BIT] &&
                    (lvl1 == efs_pkg::OC_LEVEL_NONE) && (lvl2 == efs_pkg::OC_LEVEL_NONE);

  for (genvar g = 1; g <= 3; g++) begin : g_oc
    localparam int DLO = (g == 1) ? efs_pkg::CFG_OC1_DLY_LO :
                         (g == 2) ? efs_pkg::CFG_OC2_DLY_LO : efs_pkg::CFG_OC3_DLY_LO;
    wire [1:0] dcode = (g == 3) ? {1'b0, cfg_r[15]} | {cfg_r[DLO], 1'b0} : cfg_r[DLO +: 2];
    efs_oc_timer #(.DEB_W(DEB_W)) u_tmr (
      .clk          (REF_CLK),
      .rst          (RST),
      .enable       (oc_en[g]),
      .debounce_cyc (deb_cycles(dcode)),
      .over         (OC_OVER[g]),
      .below_hyst   (OC_BELOW_HYST[g]),
      .expired      (oc_exp[g])
    );
  end

  // ------------------------------------------------------------
  // Fault lines, status and pins
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      on_d_r     <= 1'b0;
      fc_dly_r   <= '0;
      fc_drive_r <= 1'b0;
      fr_drive_r <= 1'b0;
      alert_r    <= 1'b0;
    end else begin
      on_d_r <= ON;
      // slave reports own fault on the report line
      if (running && is_slave && own_fault) fr_drive_r <= 1'b1;
      else if (state_r == S_OFF || state_r == S_SOFT && cnt_r == '0) fr_drive_r <= 1'b0;
      // master commands shutdown, at once on own fault, delayed after a slave report
      if (running && is_master && own_fault) fc_drive_r <= 1'b1;
      else if (is_master && fc_dly_r >= 8'(efs_pkg::FC_DLY_CYC - 1)) fc_drive_r <= 1'b1;
      else if (!running) fc_drive_r <= 1'b0;
      // Saturating count, so a held report keeps the command asserted
      fc_dly_r <= (is_master && !FAULT_RPT_N_I) ? ((fc_dly_r == '1) ? fc_dly_r : fc_dly_r + 8'(1)) : '0;
      // alert on health faults, not latched for input-output short
      alert_r <= ds_short || (dg_short) || (running && health) ||
                 (alert_r && (state_r == S_LATCH || state_r == S_WAIT));
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pg_flag_r  <= 1'b1;
      gok_r      <= 1'b0;
      temp_bit_r <= 1'b0;
      oc_flag_r  <= 1'b0;
      thermal_r  <= 1'b0;
    end else begin
      pg_flag_r  <= (state_nxt != S_ON);
      gok_r      <= ds_short || dg_short || ss_bad || (gok_r && state_r != S_SOFT);
      // temperature bit, set wins over read clear
      temp_bit_r <= temp_warn || (temp_bit_r && !(REG_RD && REG_ADDR == efs_pkg::OFS_STATUS));
      oc_flag_r  <= (running && oc_fault) || (oc_flag_r && !(REG_RD && REG_ADDR == efs_pkg::OFS_STATUS));
      thermal_r  <= (running && temp_sd) || (thermal_r && state_r != S_SOFT);
    end
  end

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  wire peak_rd  = REG_RD && (REG_ADDR == efs_pkg::OFS_PEAK_CURRENT);
  wire oc_entry = |(OC_OVER & oc_en);
  wire peak_up  = oc_entry && (CURRENT_MONITOR > peak_r);
  wire [15:0] status_word = 16'({thermal_r, !running, oc_flag_r, invalid_thr, gok_r, temp_bit_r, pg_flag_r});

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      tsd_r   <= efs_pkg::RST_THERMAL_SHUTDOWN;
      twarn_r <= efs_pkg::RST_THERMAL_WARNING;
      inov_r  <= efs_pkg::RST_INPUT_OV;
      cfg_r   <= efs_pkg::RST_PROTECTION_CFG;
    end else if (REG_WR) begin
      case (REG_ADDR)
        efs_pkg::OFS_THERMAL_SHUTDOWN: tsd_r   <= REG_WDATA;
        efs_pkg::OFS_THERMAL_WARNING:  twarn_r <= REG_WDATA;
        efs_pkg::OFS_INPUT_OV:         inov_r  <= REG_WDATA;
        efs_pkg::OFS_PROTECTION_CFG:   cfg_r   <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // peak capture, higher peak wins over read clear, enable does not clear
  always_ff @(posedge REF_CLK) begin
    if (RST) peak_r <= '0;
    else if (peak_up) peak_r <= CURRENT_MONITOR;
    else if (peak_rd) peak_r <= '0;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_r <= '0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        efs_pkg::OFS_THERMAL_SHUTDOWN: rdata_r <= tsd_r;
        efs_pkg::OFS_THERMAL_WARNING:  rdata_r <= twarn_r;
        efs_pkg::OFS_INPUT_OV:         rdata_r <= inov_r;
        efs_pkg::OFS_PEAK_CURRENT:     rdata_r <= 16'(peak_r);
        efs_pkg::OFS_PROTECTION_CFG:   rdata_r <= cfg_r;
        efs_pkg::OFS_STATUS:           rdata_r <= status_word;
        default:                       rdata_r <= '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // start limit select
  wire [7:0] lim_lo = VOUT_ABOVE_0P8 ? efs_pkg::LIM_LO_2 : VOUT_ABOVE_0P4 ? efs_pkg::LIM_LO_1 : efs_pkg::LIM_LO_0;
  wire [7:0] lim_hi = VOUT_ABOVE_0P8 ? efs_pkg::LIM_HI_2 : VOUT_ABOVE_0P4 ? efs_pkg::LIM_HI_1 : efs_pkg::LIM_HI_0;
  logic gate_r, fast_r, ocp_r, pg_r;
  logic [7:0] lim_r;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      gate_r <= 1'b0;
      fast_r <= 1'b0;
      ocp_r  <= 1'b0;
      pg_r   <= 1'b0;
      lim_r  <= efs_pkg::LIM_HI_0;
    end else begin
      gate_r <= (state_nxt == S_SOFT) || (state_nxt == S_ON);
      // severe short pulls the gate fast
      fast_r <= SHORT_DETECT;
      ocp_r  <= (state_nxt == S_ON);
      pg_r   <= (state_nxt == S_ON);
      lim_r  <= VIN_ABOVE_13V2 ? lim_hi : lim_lo;
    end
  end

  assign GATE_ON                = gate_r;
  assign GATE_PULL_FAST         = fast_r;
  assign START_LIMIT            = lim_r;
  assign OCP_ACTIVE             = ocp_r;
  assign OC_LEVEL1              = cfg_r[efs_pkg::CFG_OC1_LVL_LO +: 2];
  assign OC_LEVEL2              = cfg_r[efs_pkg::CFG_OC2_LVL_LO +: 2];
  assign REG_RDATA              = rdata_r;
  assign POWER_GOOD_OUTPUT_O    = 1'b0;
  assign POWER_GOOD_OUTPUT_OE_N = pg_r;
  assign ALERT_N_O              = 1'b0;
  assign ALERT_N_OE_N           = !alert_r;
  assign FAULT_CMD_N_O          = 1'b0;
  assign FAULT_CMD_N_OE_N       = !fc_drive_r;
  assign FAULT_RPT_N_O          = 1'b0;
  assign FAULT_RPT_N_OE_N       = !fr_drive_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_pg_low_soft: assert property (@(posedge REF_CLK) disable iff (RST)
    (state_r == S_SOFT && !pg_ok) |=> !POWER_GOOD_OUTPUT_OE_N) else $error("pg released early");
  a_fault_drops_pg: assert property (@(posedge REF_CLK) disable iff (RST)
    (state_r == S_ON && fault) |=> !POWER_GOOD_OUTPUT_OE_N && !OCP_ACTIVE) else $error("pg high on fault");
  a_retry_waits_cool: assert property (@(posedge REF_CLK) disable iff (RST)
    (state_r == S_WAIT && !cool) |=> state_r != S_SOFT) else $error("retry while hot");
  a_peak_monotonic: assert property (@(posedge REF_CLK) disable iff (RST)
    (!peak_rd) |=> peak_r >= $past(peak_r)) else $error("peak dropped");
  a_limit_low_vin: assert property (@(posedge REF_CLK) disable iff (RST)
    (!VIN_ABOVE_13V2 && !VOUT_ABOVE_0P4 && !VOUT_ABOVE_0P8) |=> START_LIMIT == efs_pkg::LIM_LO_0) else $error("bad limit");
  a_limit_high_vin: assert property (@(posedge REF_CLK) disable iff (RST)
    (VIN_ABOVE_13V2 && VOUT_ABOVE_0P8) |=> START_LIMIT == efs_pkg::LIM_HI_2) else $error("bad limit");
  a_ocp_after_pg: assert property (@(posedge REF_CLK) disable iff (RST)
    OCP_ACTIVE |-> POWER_GOOD_OUTPUT_OE_N) else $error("ocp without pg");
  a_latch_mode: assert property (@(posedge REF_CLK) disable iff (RST)
    (state_r == S_LATCH && !on_rise) |=> state_r == S_LATCH) else $error("latch released");
  a_short_fast: assert property (@(posedge REF_CLK) disable iff (RST)
    SHORT_DETECT |=> GATE_PULL_FAST) else $error("no fast pull");
  a_invalid_flag: assert property (@(posedge REF_CLK) disable iff (RST)
    (REG_RD && REG_ADDR == efs_pkg::OFS_STATUS && invalid_thr) |=> REG_RDATA[efs_pkg::ST_INVALID_BIT]) else $error("no invalid");

endmodule

// File: sim/efs_peer.sv
// Paralleled fuse model on the two shared fault lines
module efs_peer (
  // Design enables, low while driving low
  input  wire logic cmd_oe_n,
  input  wire logic rpt_oe_n,
  // Peer fault report
  input  wire logic peer_rpt,
  // Wire levels, pulled up when released
  output logic      cmd_n,
  output logic      rpt_n
);
  timeunit 1ns;
  timeprecision 1ps;
  assign rpt_n = rpt_oe_n & ~peer_rpt;
  assign cmd_n = cmd_oe_n;
endmodule

// File: sim/test_efuse_fault_supervisor.sv
// Self-checking bench of the fuse fault supervisor
module test_efuse_fault_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, on = 0, hen = 0, vin_hi = 0, a04 = 0, a08 = 0, near = 0, vgs = 0;
  logic wr = 0, rd = 0, peer_rpt = 0, lo = 0, hi = 1, cmd_n, rpt_n, cmd_oe_n, rpt_oe_n, pg_oe_n, ocp;
  logic sc = 0, gate, fast;
  logic [3:1] over = 3'h0;
  logic [9:0] cur = 10'h000;
  logic [7:0] addr = 8'h00, slim;
  logic [1:0] lvl1, lvl2, role = 2'h0;
  logic [15:0] wd = 16'h0000, rdata, d, temp = 16'h0010;
  int i, err_count = 0, comparisons = 0;
  integer seed = 32'hCC65;
  int lim[6] = '{15, 30, 60, 10, 20, 40};
  logic [7:0] ra[6] = '{8'h4F, 8'h51, 8'h55, 8'hC9, 8'hC4, 8'h00};
  logic [15:0] rv[6] = '{16'h0096, 16'h0082, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
  efs_supervisor #(.RETRY_CYC(20), .CLREG_CYC(10), .SSFLT_CYC(200)) uut (
    .REF_CLK(clk), .RST(rst), .ON(on), .HOST_ENABLE(hen), .ROLE(role),
    .VOUT_NEAR_VIN(near), .VGS_ABOVE_6V3(vgs), .VIN_ABOVE_13V2(vin_hi), .VOUT_ABOVE_0P4(a04),
    .VOUT_ABOVE_0P8(a08), .VOUT_ABOVE_LOW_TH(near), .VGS_ABOVE_GATE_TH(vgs), .IN_CURRENT_LIMIT(lo),
    .SHORT_DETECT(sc), .VOUT_ABOVE_DS_TH(lo), .VOUT_BELOW_DS_OK(hi), .GATE_ABOVE_DG_TH(lo),
    .VIN_FAULT(lo), .OC_OVER(over), .OC_BELOW_HYST(~over), .CURRENT_MONITOR(cur), .DIE_TEMP(temp),
    .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wd), .REG_RDATA(rdata), .GATE_ON(gate),
    .GATE_PULL_FAST(fast), .START_LIMIT(slim), .OCP_ACTIVE(ocp), .OC_LEVEL1(lvl1), .OC_LEVEL2(lvl2),
    .POWER_GOOD_OUTPUT_O(), .POWER_GOOD_OUTPUT_OE_N(pg_oe_n), .ALERT_N_O(), .ALERT_N_OE_N(),
    .FAULT_CMD_N_I(cmd_n), .FAULT_CMD_N_O(), .FAULT_CMD_N_OE_N(cmd_oe_n), .FAULT_RPT_N_I(rpt_n),
    .FAULT_RPT_N_O(), .FAULT_RPT_N_OE_N(rpt_oe_n));
  efs_peer peer (.cmd_oe_n(cmd_oe_n), .rpt_oe_n(rpt_oe_n), .peer_rpt(peer_rpt), .cmd_n(cmd_n), .rpt_n(rpt_n));
  initial begin
    forever #2 clk = ~clk;
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(negedge clk) addr = a;
    rd = 1;
    @(negedge clk) rd = 0;
    @(negedge clk) v = rdata;
  endtask
  task wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(negedge clk) addr = a;
    wd = v;
    wr = 1;
    @(negedge clk) wr = 0;
  endtask
  task tally_and_finish;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    rst = 0;
    for (i = 0; i < 6; i++) begin
      rd_reg(ra[i], d);
      chk("reset value", rv[i], d);
    end
    wr_reg(8'hC9, 16'h0005);
    rd_reg(8'hC9, d);
    chk("config", 16'h0005, d);
    chk("level1 field", 16'h0001, {14'h0, lvl1});
    on = 1;
    hen = 1;
    for (i = 0; i < 6; i++) begin
      @(negedge clk) vin_hi = i > 2;
      a04 = i % 3 > 0;
      a08 = i % 3 > 1;
      repeat (3) @(negedge clk);
      chk("start limit", lim[i][15:0], {8'h00, slim});
    end
    chk("pg held low", 16'h0000, {15'h0, pg_oe_n});
    near = 1;
    vgs = 1;
    repeat (4) @(negedge clk);
    chk("pg released", 16'h0001, {15'h0, pg_oe_n});
    chk("ocp active", 16'h0001, {15'h0, ocp});
    rd_reg(8'hE0, d);
    chk("pg flag", 16'h0000, {15'h0, d[0]});
    cur = 10'($random(seed));
    over[1] = 1;
    repeat (3) @(negedge clk);
    over[1] = 0;
    rd_reg(8'hC4, d);
    chk("peak", {6'h00, cur}, d);
    rd_reg(8'hC4, d);
    chk("peak cleared", 16'h0000, d);
    hen = 0;
    repeat (4) @(negedge clk);
    chk("pg on disable", 16'h0000, {15'h0, pg_oe_n});
    rd_reg(8'hE0, d);
    chk("pg flag set", 16'h0001, {15'h0, d[0]});
    hen = 1;
    repeat (4) @(negedge clk);
    chk("pg re-enabled", 16'h0001, {15'h0, pg_oe_n});
    temp = 16'h0090;
    @(negedge clk) chk("pg on warning", 16'h0001, {15'h0, pg_oe_n});
    temp = 16'h0010;
    rd_reg(8'hE0, d);
    chk("temp bit", 16'h0001, {15'h0, d[1]});
    rd_reg(8'hE0, d);
    chk("temp bit cleared", 16'h0000, {15'h0, d[1]});
    sc = 1;
    @(negedge clk) chk("fast pull", 16'h0001, {15'h0, fast});
    chk("gate off on short", 16'h0000, {15'h0, gate});
    chk("pg on short", 16'h0000, {15'h0, pg_oe_n});
    sc = 0;
    repeat (10) @(negedge clk);
    chk("pg in retry delay", 16'h0000, {15'h0, pg_oe_n});
    repeat (20) @(negedge clk);
    chk("pg after retry", 16'h0001, {15'h0, pg_oe_n});
    wr_reg(8'hC9, 16'h0041);
    chk("levels off", 16'h0000, {12'h0, lvl2, lvl1});
    cur = 10'($random(seed));
    over[3] = 1;
    repeat (3) @(negedge clk);
    over[3] = 0;
    rd_reg(8'hC4, d);
    chk("peak level3", {6'h00, cur}, d);
    role = 2'h1;
    peer_rpt = 1;
    repeat (120) @(negedge clk);
    chk("command held", 16'h0001, {15'h0, cmd_oe_n});
    repeat (10) @(negedge clk);
    chk("command driven", 16'h0000, {15'h0, cmd_oe_n});
    chk("master off", 16'h0000, {15'h0, pg_oe_n});
    peer_rpt = 0;
    repeat (30) @(negedge clk);
    chk("command released", 16'h0001, {15'h0, cmd_oe_n});
    chk("master restarted", 16'h0001, {15'h0, pg_oe_n});
    tally_and_finish;
  end
  initial begin
    #20000;
    err_count++;
    tally_and_finish;
  end
endmodule
